/* File: rtl/vic_pkg.sv */
package vic_pkg;

  // Register indices on the host register port
  localparam logic [3:0] REG_FIXED_VEC = 4'h0;
  localparam logic [3:0] REG_MOD_VEC = 4'h1;
  localparam logic [3:0] REG_CTRL = 4'h2;
  localparam logic [3:0] REG_SER_ST = 4'h3;
  localparam logic [3:0] REG_DMA_ST = 4'h4;
  localparam logic [3:0] REG_TMR_ST = 4'h5;
  localparam logic [3:0] REG_SER_EN = 4'h6;
  localparam logic [3:0] REG_DMA_EN = 4'h7;
  localparam logic [3:0] REG_TMR_EN = 4'h8;

  // Control register field positions
  localparam int CTRL_SWAP_BIT = 7;
  localparam int CTRL_ACK_HI_BIT = 6;
  localparam int CTRL_ACK_LO_BIT = 5;
  localparam int CTRL_VSEL_BIT = 4;

  // Reset values
  localparam logic [7:0] FIXED_VEC_RST = 8'h00;
  localparam logic [1:0] USER_VEC_RST = 2'h0;
  localparam logic [7:0] EN_RST = 8'h00;

  // Source counts and ranges in default priority order
  localparam int NUM_SRC = 20;
  localparam int SER_LO = 0;
  localparam int DMA_LO = 8;
  localparam int TMR_LO = 16;

  // Acknowledge cycle types
  localparam logic [1:0] ACK_NONE = 2'h0;
  localparam logic [1:0] ACK_SINGLE = 2'h1;
  localparam logic [1:0] ACK_DOUBLE = 2'h2;

  typedef enum logic [1:0] {ACK_IDLE, ACK_ARMED, ACK_DRIVE} vic_ack_state_t;

  // Six-bit source code for a source index in default priority order
  function automatic logic [5:0] src_code(input logic [4:0] idx);
    logic [4:0] j;
    j = 5'h00;
    if (idx < 5'd8) begin
      return {idx[2], 1'b0, 3'({1'b0, idx[1:0]} + 3'h2), 1'b0};
    end else if (idx < 5'd16) begin
      j = idx - 5'd8;
      return {j[2], 1'b1, 3'({1'b0, j[1], j[0]} + 3'h2), 1'b0};
    end else begin
      j = idx - 5'd16;
      return {j[1], 3'h7, j[0], 1'b0};
    end
  endfunction

endpackage

/* File: rtl/vic_prio_enc.sv */
`timescale 1ns/1ps
module vic_prio_enc #(
  parameter int NSRC = 20
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Pending sources and order select
  input wire logic [NSRC-1:0] pend,
  input wire logic swap,
  // Winning code
  output logic [5:0] code_q,
  output logic any_q
);

  logic [4:0] ser_idx, dma_idx, tmr_idx, win_idx;
  logic ser_hit, dma_hit, tmr_hit;

  // Lowest index pending within each group
  always_comb begin
    ser_idx = 5'h00;
    dma_idx = 5'h00;
    tmr_idx = 5'h00;
    ser_hit = 1'b0;
    dma_hit = 1'b0;
    tmr_hit = 1'b0;
    for (int i = vic_pkg::DMA_LO - 1; i >= vic_pkg::SER_LO; i--) begin
      if (pend[i]) begin
        ser_idx = 5'(i);
        ser_hit = 1'b1;
      end
    end
    for (int i = vic_pkg::TMR_LO - 1; i >= vic_pkg::DMA_LO; i--) begin
      if (pend[i]) begin
        dma_idx = 5'(i);
        dma_hit = 1'b1;
      end
    end
    for (int i = NSRC - 1; i >= vic_pkg::TMR_LO; i--) begin
      if (pend[i]) begin
        tmr_idx = 5'(i);
        tmr_hit = 1'b1;
      end
    end
  end

  // Group order: serial before DMA unless swapped; timers always last
  always_comb begin
    if (swap && dma_hit) begin
      win_idx = dma_idx;
    end else if (ser_hit) begin
      win_idx = ser_idx;
    end else if (dma_hit) begin
      win_idx = dma_idx;
    end else begin
      win_idx = tmr_idx;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      code_q <= 6'h00;
      any_q <= 1'b0;
    end else if (ce) begin
      code_q <= vic_pkg::src_code(win_idx);
      any_q <= ser_hit | dma_hit | tmr_hit;
    end
  end

endmodule // vic_prio_enc

/* File: rtl/vic_top.sv */
`timescale 1ns/1ps
module vic_top (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Source request lines
  input wire logic [7:0] serial_req,
  input wire logic [7:0] dma_req,
  input wire logic [3:0] timer_req,
  // Host register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // Host interrupt pins
  output logic irq_n_q,
  input wire logic irq_ack_n,
  output logic [7:0] vec_data_q,
  output logic vec_oe_q
);

  logic [7:0] fixed_vector_q;
  logic [1:0] user_vec_q;
  logic priority_swap_q, vector_select_q;
  logic [1:0] ack_type_q;
  logic [7:0] serial_irq_status_q, dma_irq_status_q;
  logic [3:0] timer_irq_status_q;
  logic [7:0] serial_irq_enable_q, dma_irq_enable_q;
  logic [3:0] timer_irq_enable_q;
  logic [19:0] pend;
  logic [5:0] code_q;
  logic any_q;
  logic ack_prev_q;
  logic ack_fall;
  logic [7:0] sel_vec;
  logic [7:0] rdata_d;
  vic_pkg::vic_ack_state_t state_q;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r, input logic wr);
    return wr && (a == r);
  endfunction

  // Status mirrors the source lines; clearing happens at the source
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      serial_irq_status_q <= 8'h00;
      dma_irq_status_q <= 8'h00;
      timer_irq_status_q <= 4'h0;
    end else if (ce) begin
      serial_irq_status_q <= serial_req;
      dma_irq_status_q <= dma_req;
      timer_irq_status_q <= timer_req;
    end
  end

  // Host-writable registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fixed_vector_q <= vic_pkg::FIXED_VEC_RST;
      user_vec_q <= vic_pkg::USER_VEC_RST;
      priority_swap_q <= 1'b0;
      ack_type_q <= vic_pkg::ACK_NONE;
      vector_select_q <= 1'b0;
      serial_irq_enable_q <= vic_pkg::EN_RST;
      dma_irq_enable_q <= vic_pkg::EN_RST;
      timer_irq_enable_q <= 4'h0;
    end else if (ce) begin
      if (hit(reg_addr, vic_pkg::REG_FIXED_VEC, reg_wr)) begin
        fixed_vector_q <= reg_wdata;
      end
      if (hit(reg_addr, vic_pkg::REG_MOD_VEC, reg_wr)) begin
        user_vec_q <= reg_wdata[7:6];
      end
      if (hit(reg_addr, vic_pkg::REG_CTRL, reg_wr)) begin
        priority_swap_q <= reg_wdata[vic_pkg::CTRL_SWAP_BIT];
        ack_type_q <= {reg_wdata[vic_pkg::CTRL_ACK_HI_BIT], reg_wdata[vic_pkg::CTRL_ACK_LO_BIT]};
        vector_select_q <= reg_wdata[vic_pkg::CTRL_VSEL_BIT];
      end
      if (hit(reg_addr, vic_pkg::REG_SER_EN, reg_wr)) begin
        serial_irq_enable_q <= reg_wdata;
      end
      if (hit(reg_addr, vic_pkg::REG_DMA_EN, reg_wr)) begin
        dma_irq_enable_q <= reg_wdata;
      end
      if (hit(reg_addr, vic_pkg::REG_TMR_EN, reg_wr)) begin
        timer_irq_enable_q <= reg_wdata[7:4];
      end
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    unique case (reg_addr)
      vic_pkg::REG_FIXED_VEC: rdata_d = fixed_vector_q;
      vic_pkg::REG_MOD_VEC: rdata_d = {user_vec_q, 6'h00};
      vic_pkg::REG_CTRL: rdata_d = {priority_swap_q, ack_type_q, vector_select_q, 4'h0};
      vic_pkg::REG_SER_ST: rdata_d = serial_irq_status_q;
      vic_pkg::REG_DMA_ST: rdata_d = dma_irq_status_q;
      vic_pkg::REG_TMR_ST: rdata_d = {timer_irq_status_q, 4'h0};
      vic_pkg::REG_SER_EN: rdata_d = serial_irq_enable_q;
      vic_pkg::REG_DMA_EN: rdata_d = dma_irq_enable_q;
      vic_pkg::REG_TMR_EN: rdata_d = {timer_irq_enable_q, 4'h0};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (ce && reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // Gating and request output
  // Pin is registered so sources settling mid-cycle never glitch it
  assign pend = {timer_irq_status_q & timer_irq_enable_q,
                 dma_irq_status_q & dma_irq_enable_q,
                 serial_irq_status_q & serial_irq_enable_q};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_n_q <= 1'b1;
    end else if (ce) begin
      irq_n_q <= ~|pend;
    end
  end

  // Code is registered; the vector lags pending changes by one cycle
  vic_prio_enc #(
    .NSRC(vic_pkg::NUM_SRC)
  ) u_enc (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .pend(pend),
    .swap(priority_swap_q),
    .code_q(code_q),
    .any_q(any_q)
  );

  assign sel_vec = vector_select_q ? {user_vec_q, code_q} : fixed_vector_q;
  // Detector idles high like the pin, so leaving reset never looks like a fall
  assign ack_fall = ack_prev_q && !irq_ack_n;

  // Acknowledge sequencing; type 11 is treated like 00
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_prev_q <= 1'b1;
      state_q <= vic_pkg::ACK_IDLE;
      vec_oe_q <= 1'b0;
      vec_data_q <= 8'h00;
    end else if (ce) begin
      ack_prev_q <= irq_ack_n;
      unique case (state_q)
        vic_pkg::ACK_IDLE: begin
          if (ack_fall && !irq_n_q) begin
            if (ack_type_q == vic_pkg::ACK_SINGLE) begin
              state_q <= vic_pkg::ACK_DRIVE;
              vec_oe_q <= 1'b1;
              vec_data_q <= sel_vec;
            end else if (ack_type_q == vic_pkg::ACK_DOUBLE) begin
              state_q <= vic_pkg::ACK_ARMED;
            end
          end
        end
        vic_pkg::ACK_ARMED: begin
          if (ack_type_q != vic_pkg::ACK_DOUBLE) begin
            state_q <= vic_pkg::ACK_IDLE;
          end else if (ack_fall) begin
            if (!irq_n_q) begin
              state_q <= vic_pkg::ACK_DRIVE;
              vec_oe_q <= 1'b1;
              vec_data_q <= sel_vec;
            end else begin
              state_q <= vic_pkg::ACK_IDLE;
            end
          end
        end
        vic_pkg::ACK_DRIVE: begin
          // Bus released as soon as the acknowledge is withdrawn
          if (irq_ack_n) begin
            state_q <= vic_pkg::ACK_IDLE;
            vec_oe_q <= 1'b0;
          end
        end
        default: begin
          state_q <= vic_pkg::ACK_IDLE;
          vec_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || !ce);

  sequence s_ack_idle(logic [1:0] t);
    state_q == vic_pkg::ACK_IDLE && ack_type_q == t && ack_fall;
  endsequence

  // Fall that starts the drive phase, from either acknowledge type
  sequence s_drive_edge;
    ack_fall && !irq_n_q &&
        ((state_q == vic_pkg::ACK_IDLE && ack_type_q == vic_pkg::ACK_SINGLE) ||
         (state_q == vic_pkg::ACK_ARMED && ack_type_q == vic_pkg::ACK_DOUBLE));
  endsequence

  sequence s_armed_fall;
    state_q == vic_pkg::ACK_ARMED && ack_type_q == vic_pkg::ACK_DOUBLE && ack_fall && !irq_n_q;
  endsequence

  // Request output
  chk_irq_level: assert property (ce |=> irq_n_q == !$past(|pend))
    else $error("request output does not follow gated status");
  chk_any_match: assert property (any_q == !irq_n_q)
    else $error("encoder hit flag and request output disagree");

  // Register read-back
  chk_ctrl_reserved: assert property (
      (reg_rd && reg_addr == vic_pkg::REG_CTRL) |=> reg_rdata_q[3:0] == 4'h0)
    else $error("control reserved bits not zero");
  chk_mv_low_zero: assert property (
      (reg_rd && reg_addr == vic_pkg::REG_MOD_VEC) |=> reg_rdata_q[5:0] == 6'h00)
    else $error("modified vector low bits not zero on read");
  chk_user_bits: assert property (
      (reg_rd && reg_addr == vic_pkg::REG_MOD_VEC) |=> reg_rdata_q[7:6] == $past(user_vec_q))
    else $error("modified vector user bits read back wrong");
  chk_tmr_low_zero: assert property (
      (reg_rd && reg_addr == vic_pkg::REG_TMR_ST) |=> reg_rdata_q[3:0] == 4'h0)
    else $error("timer status reserved bits not zero");

  // Acknowledge sequencing
  chk_none_float: assert property (
      s_ack_idle(vic_pkg::ACK_NONE) |=> !vec_oe_q)
    else $error("bus driven in non-acknowledge mode");
  chk_single_drive: assert property (
      (s_ack_idle(vic_pkg::ACK_SINGLE) and !irq_n_q)
      |=> vec_oe_q && vec_data_q == $past(sel_vec))
    else $error("single acknowledge did not drive vector");
  chk_double_first: assert property (
      (s_ack_idle(vic_pkg::ACK_DOUBLE) and !irq_n_q)
      |=> !vec_oe_q && state_q == vic_pkg::ACK_ARMED)
    else $error("first acknowledge of double cycle drove bus");
  chk_double_second: assert property (
      s_armed_fall |=> vec_oe_q && vec_data_q == $past(sel_vec))
    else $error("second acknowledge of double cycle did not drive vector");
  chk_no_req_float: assert property (
      (ack_fall && irq_n_q && state_q != vic_pkg::ACK_DRIVE) |=> !vec_oe_q)
    else $error("vector driven with no request pending");
  chk_idle_float: assert property (state_q == vic_pkg::ACK_IDLE |-> !vec_oe_q)
    else $error("bus driven while no acknowledge is in progress");
  chk_armed_float: assert property (state_q == vic_pkg::ACK_ARMED |-> !vec_oe_q)
    else $error("bus driven between the two acknowledges");
  chk_release: assert property (
      (state_q == vic_pkg::ACK_DRIVE && irq_ack_n) |=> !vec_oe_q)
    else $error("bus not released after acknowledge withdrawn");
  chk_fixed_pick: assert property (
      (s_drive_edge and !vector_select_q) |=> vec_data_q == $past(fixed_vector_q))
    else $error("fixed vector not driven with select clear");
  chk_mod_pick: assert property (
      (s_drive_edge and vector_select_q) |=> vec_data_q == {$past(user_vec_q), $past(code_q)})
    else $error("modified vector not driven with select set");
  chk_vec_stable: assert property ((vec_oe_q && $past(vec_oe_q)) |-> $stable(vec_data_q))
    else $error("vector changed while driven");

  // Status and priority
  chk_status_follow: assert property (
      ce |=> serial_irq_status_q == $past(serial_req) && dma_irq_status_q == $past(dma_req))
    else $error("status does not follow source lines");
  chk_swap_order: assert property (
      (|pend[7:0] && |pend[15:8]) |=> code_q[4] == $past(priority_swap_q))
    else $error("serial and DMA precedence wrong");
  chk_timer_last: assert property (
      ((pend[15:0] == 16'h0000) && |pend[19:16]) |=> code_q[4:2] == 3'h7)
    else $error("timer code not chosen when only timers pend");

  // Clock enable low holds every output
  chk_ce_freeze: assert property (@(posedge mclk) disable iff (rst)
      !ce |=> $stable(irq_n_q) && $stable(vec_oe_q) && $stable(vec_data_q) && $stable(reg_rdata_q))
    else $error("output moved while clock enable low");

endmodule // vic_top

/* File: tb/vectored_interrupt_controller_test.sv */
`timescale 1ns/1ps
module vectored_interrupt_controller_test;
  logic mclk, rst, ce, reg_wr, reg_rd, irq_n_q, irq_ack_n, vec_oe_q;
  logic [7:0] serial_req, dma_req, reg_wdata, reg_rdata_q, vec_data_q;
  logic [3:0] timer_req, reg_addr;
  logic [7:0] m_reg [0:8];
  int num_errors = 0;
  int n_compared = 0;
  int seed = 6;

  vic_top i_dut (.mclk(mclk), .rst(rst), .ce(ce), .serial_req(serial_req),
    .dma_req(dma_req), .timer_req(timer_req), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .irq_n_q(irq_n_q),
    .irq_ack_n(irq_ack_n), .vec_data_q(vec_data_q), .vec_oe_q(vec_oe_q));
  vic_host_model i_host (.mclk(mclk), .irq_n_q(irq_n_q), .vec_data_q(vec_data_q),
    .vec_oe_q(vec_oe_q), .irq_ack_n(irq_ack_n));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Write strobe for one cycle; model keeps only writable places
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
    if (a inside {0, 1, 2, 6, 7, 8}) m_reg[a] = d;
    // Idle edge so a following call never re-raises the strobe in this step
    @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    d = reg_rdata_q;
    @(posedge mclk);
    #1;
  endtask

  function automatic logic [7:0] exp_rd(input logic [3:0] a);
    case (a)
      3: return serial_req;
      4: return dma_req;
      5: return {timer_req, 4'h0};
      15: return 8'h00;
      default: return m_reg[a];
    endcase
  endfunction

  function automatic logic [5:0] exp_code(input logic [19:0] p, input logic sw);
    int i;
    for (int k = 0; k < 20; k++) begin
      i = (sw && k < 16) ? (k + 8) % 16 : k;
      if (p[i] && i < 16) return {i[2], i >= 8, 3'(i % 4 + 2), 1'b0};
      if (p[i]) return {i[1], 3'h7, i[0], 1'b0};
    end
    return 6'h00;
  endfunction

  task automatic check_regs();
    logic [7:0] d;
    for (int a = 0; a < 10; a++) begin
      rd(a == 9 ? 4'hf : 4'(a), d);
      chk("register", d, exp_rd(a == 9 ? 4'hf : 4'(a)));
    end
  endtask

  initial begin
    #200000;
    num_errors++;
    conclude();
  end

  initial begin
    logic [31:0] r;
    logic [7:0] d, v, exp_v;
    logic [19:0] pend;
    int ty, drv, exp_drv;
    rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    serial_req = 8'h00;
    dma_req = 8'h00;
    timer_req = 4'h0;
    foreach (m_reg[i]) m_reg[i] = 8'h00;
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    chk("irq_n", {7'h0, irq_n_q}, 8'h01);
    chk("vec_oe", {7'h0, vec_oe_q}, 8'h00);
    check_regs();
    for (int it = 0; it < 45; it++) begin
      ty = it % 3;
      r = $random(seed);
      serial_req = r[7:0];
      dma_req = r[15:8];
      timer_req = r[19:16];
      for (int a = 0; a < 10; a++) begin
        r = $random(seed);
        d = (a == 6 || a == 7) ? r[7:0] & r[15:8] : r[7:0];
        if (a == 1) d[5:0] = 6'h00;
        if (a == 2) d = {d[7], 2'(ty), d[4], 4'h0};
        if (a == 8) d[3:0] = 4'h0;
        wr(a == 9 ? 4'hf : 4'(a), d);
      end
      repeat (3) @(posedge mclk);
      #1;
      check_regs();
      pend = {timer_req & m_reg[8][7:4], dma_req & m_reg[7], serial_req & m_reg[6]};
      chk("irq_n", {7'h0, irq_n_q}, {7'h0, ~|pend});
      exp_v = m_reg[2][4] ? {m_reg[1][7:6], exp_code(pend, m_reg[2][7])} : m_reg[0];
      exp_drv = (|pend && ty != 0) ? ty : 0;
      r = $random(seed);
      i_host.acknowledge(ty == 2 ? 2 : 1, 2 + int'(r[1:0]), drv, v);
      chk("ack_drive", 8'(drv), 8'(exp_drv));
      if (exp_drv != 0) chk("vector", v, exp_v);
      chk("vec_oe_idle", {7'h0, vec_oe_q}, 8'h00);
    end
    // Clock enable low: sources move, request output must hold
    d = {7'h0, irq_n_q};
    ce = 1'b0;
    serial_req = ~serial_req;
    dma_req = ~dma_req;
    timer_req = ~timer_req;
    repeat (4) @(posedge mclk);
    #1;
    chk("irq_n_frozen", {7'h0, irq_n_q}, d);
    ce = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    pend = {timer_req & m_reg[8][7:4], dma_req & m_reg[7], serial_req & m_reg[6]};
    chk("irq_n", {7'h0, irq_n_q}, {7'h0, ~|pend});
    // Mid-run reset returns every writable field to zero
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    foreach (m_reg[i]) m_reg[i] = 8'h00;
    chk("irq_n", {7'h0, irq_n_q}, 8'h01);
    chk("vec_oe", {7'h0, vec_oe_q}, 8'h00);
    check_regs();
    // Single type, modified vector, nothing enabled: acknowledge must not drive
    wr(4'h2, 8'h30);
    i_host.acknowledge(1, 2, drv, v);
    chk("ack_no_req", 8'(drv), 8'h00);
    conclude();
  end
endmodule // vectored_interrupt_controller_test

/* File: tb/vic_host_model.sv */
`timescale 1ns/1ps
module vic_host_model (
  // Clock
  input wire logic mclk,
  // Interrupt pins
  input wire logic irq_n_q,
  input wire logic [7:0] vec_data_q,
  input wire logic vec_oe_q,
  output logic irq_ack_n
);
  // Idle level stays high, as a pull-up would hold it
  initial irq_ack_n = 1'b1;

  // Drives n_acks low pulses; drv_at is the pulse number that got a vector
  task automatic acknowledge(input int n_acks, input int low_len, output int drv_at,
                             output logic [7:0] vec);
    drv_at = 0;
    vec = 8'h00;
    for (int k = 1; k <= n_acks; k++) begin
      irq_ack_n = 1'b0;
      repeat (low_len) begin
        @(posedge mclk);
        // Look once the edge has settled, never in its own time step
        #1;
        if (vec_oe_q === 1'b1 && drv_at == 0) begin
          drv_at = k;
          vec = vec_data_q;
        end
      end
      irq_ack_n = 1'b1;
      // High gap between pulses so each fall is seen apart
      repeat (3) @(posedge mclk);
      #1;
    end
  endtask
endmodule // vic_host_model
